/* File: pwmenc_host.sv */
// Host-side model that measures the pulse train of the encoder.
// Assumes the output is sampled on CLK_SYS; each period runs rising edge to rising edge.
`timescale 1ns/100ps
module pwmenc_host (
  input  wire logic        CLK_SYS,
  input  wire logic        PULSE_IN,
  output logic [31:0]      HIGH_CYC,
  output logic [31:0]      PERIOD_CYC,
  output logic [31:0]      N_DONE
);
  logic        prev_q = 1'h0;
  logic [31:0] hc_q   = 32'h0;
  logic [31:0] pc_q   = 32'h0;
  initial begin
    HIGH_CYC   = 32'h0;
    PERIOD_CYC = 32'h0;
    N_DONE     = 32'h0;
  end
  // Count high and total cycles; publish on each rising edge after the first
  always @(posedge CLK_SYS) begin
    prev_q <= PULSE_IN;
    if (PULSE_IN && !prev_q) begin
      if (pc_q != 32'h0) begin // First edge closes no period
        HIGH_CYC   <= hc_q;
        PERIOD_CYC <= pc_q;
        N_DONE     <= N_DONE + 32'h1;
      end
      hc_q <= 32'h1;
      pc_q <= 32'h1;
    end else if (pc_q != 32'h0) begin
      pc_q <= pc_q + 32'h1;
      if (PULSE_IN) hc_q <= hc_q + 32'h1;
    end
  end
endmodule

/* File: pwmenc_pkg.sv */
// Constants and types of the position pulse-width encoder.
// Assumes a single 200 MHz system clock and no software access.
package pwmenc_pkg;

  // System clock rate in Hz
  localparam int CLK_HZ        = 200_000_000;
  // Output rates in Hz
  localparam int FAST_HZ       = 350;
  localparam int SLOW_HZ       = 250;
  // Counter and position widths
  localparam int CNT_W         = 20;
  localparam int POS_W         = 12;
  localparam int PROD_W        = CNT_W + POS_W;
  // Duty limits in percent of the period
  localparam int DUTY_MIN_PCT  = 1;
  localparam int DUTY_MAX_PCT  = 99;
  localparam int PCT_FULL      = 100;
  // Position code of the sensor centre line (half scale)
  localparam logic [POS_W-1:0] POS_CENTRE = 12'h800;
  // Level of an undriven pin held up by its pull-up
  localparam logic PIN_PULLUP  = 1'h1;
  // Synchroniser depth
  localparam int SYNC_DEPTH    = 3;

  typedef enum logic [0:0] {
    ST_SLEEP = 1'h0,
    ST_RUN   = 1'h1
  } pwmenc_state_e;

endpackage

/* File: pwmenc_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to CLK_SYS; reset value is the pin's idle level.
`timescale 1ns/100ps
module pwmenc_sync #(
  parameter logic RESET_VAL = 1'h1
) (
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic PIN_IN,
  output logic      LEVEL
);
  import pwmenc_pkg::*;

  logic [SYNC_DEPTH-1:0] stage_q;

  // Shift chain; stage 0 is read only by stage 1
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      stage_q <= {SYNC_DEPTH{RESET_VAL}};
    end else begin
      stage_q <= {stage_q[SYNC_DEPTH-2:0], PIN_IN};
    end
  end

  // Level changes once stages two and three agree
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      LEVEL <= RESET_VAL;
    end else if (stage_q[1] == stage_q[2]) begin
      LEVEL <= stage_q[2];
    end
  end

endmodule

/* File: pwmenc_tb_top.sv */
// Self-checking bench for the position pulse-width encoder.
// Assumes short periods of 200 and 280 cycles; pins sit on pulled-up wires.
`timescale 1ns/100ps
module pwmenc_tb_top;
  import pwmenc_pkg::*;
  logic             clk = 1'h0, rst = 1'h1;
  logic             fs_en = 1'h0, fs_v = 1'h0, dz_en = 1'h0, dz_v = 1'h0;
  logic [POS_W-1:0] pos = POS_CENTRE;
  tri1              fs_w, dz_w;
  wire              pwo, slp;
  logic [31:0]      hi, per, n;
  int               n_fail = 0, n_checks = 0;
  // Pins float to their pull-up level unless driven
  assign fs_w = fs_en ? fs_v : 1'bz;
  assign dz_w = dz_en ? dz_v : 1'bz;
  pwmenc_top #(.PERIOD_FAST_CYC(20'hc8), .PERIOD_SLOW_CYC(20'h118)) i_dut (.CLK_SYS(clk), .RST(rst),
    .FREQUENCY_SELECT(fs_w), .DOZE_CONTROL(dz_w), .POSITION(pos), .PULSE_WIDTH_OUT(pwo), .SLEEPING(slp));
  pwmenc_host i_host (.CLK_SYS(clk), .PULSE_IN(pwo), .HIGH_CYC(hi), .PERIOD_CYC(per), .N_DONE(n));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Let three whole periods pass so the last one is clean
  task automatic settle();
    int i;
    logic [31:0] s;
    s = n;
    for (i = 0; i < 3000 && n < s + 3; i++) @(negedge clk);
    if (n < s + 3) begin
      n_fail++;
      complete_run();
    end
  endtask
  // Set rate and position, then measure one period
  task automatic run_pwm(input logic f, input logic [POS_W-1:0] p, input logic [31:0] eper, input logic [31:0] ehi);
    fs_en = ~f;
    pos = p;
    settle();
    chk("period", eper, per);
    chk("high", ehi, hi);
  endtask
  // Sleep, check a quiet output, then wake through the pull-up
  task automatic run_sleep();
    int i, c;
    c = 0;
    dz_en = 1'h1;
    for (i = 0; i < 1000 && slp !== 1'h1; i++) @(negedge clk);
    chk("sleeping", 32'h1, {31'h0, slp});
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (pwo !== 1'h0) c++;
    end
    chk("sleep_out", 32'h0, c);
    dz_en = 1'h0;
    for (i = 0; i < 20 && slp !== 1'h0; i++) @(negedge clk);
    chk("sleeping", 32'h0, {31'h0, slp});
    settle();
    chk("period", 32'hc8, per);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'h0;
    run_pwm(1'h1, POS_CENTRE, 32'hc8, 32'h64);
    run_pwm(1'h0, 12'h000, 32'h118, 32'h3);
    run_pwm(1'h0, 12'h400, 32'h118, 32'h46);
    run_pwm(1'h1, 12'hfff, 32'hc8, 32'hc6);
    run_sleep();
    complete_run();
  end
endmodule

/* File: pwmenc_top.sv */
// Pulse-width output whose high time encodes the sensed magnet position.
// Assumes POSITION comes from front-end logic on CLK_SYS; pins carry pull-ups outside.
`timescale 1ns/100ps
// Operation
// - Period is 350 Hz with frequency select high, 250 Hz with it low.
// - An undriven frequency select reads high through its pull-up, giving 350 Hz.
// - Run while doze control is high; sleep while it is held low.
// - An unconnected doze control stays high, so output keeps running.
// - High duty stays within 1 to 99 percent; never constant high or low while running.
// - High time of each period after the first following reset is proportional to the sensed position.
// - Centre-line position gives exactly 50 percent duty.
module pwmenc_top #(
  parameter logic [pwmenc_pkg::CNT_W-1:0] PERIOD_FAST_CYC =
    pwmenc_pkg::CNT_W'(pwmenc_pkg::CLK_HZ / pwmenc_pkg::FAST_HZ),
  parameter logic [pwmenc_pkg::CNT_W-1:0] PERIOD_SLOW_CYC =
    pwmenc_pkg::CNT_W'(pwmenc_pkg::CLK_HZ / pwmenc_pkg::SLOW_HZ)
) (
  input  wire logic                         CLK_SYS,
  input  wire logic                         RST,
  input  wire logic                         FREQUENCY_SELECT,
  input  wire logic                         DOZE_CONTROL,
  input  wire logic [pwmenc_pkg::POS_W-1:0] POSITION,
  output logic                              PULSE_WIDTH_OUT,
  output logic                              SLEEPING
);
  import pwmenc_pkg::*;

  logic                 freq_lvl;
  logic                 doze_lvl;
  pwmenc_state_e        state_q;
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     period_q;
  logic [CNT_W-1:0]     high_q;
  logic [CNT_W-1:0]     period_d;
  logic [CNT_W-1:0]     high_d;
  logic                 bnd;
  logic [CNT_W-1:0]     hi_run_q;
  logic [CNT_W-1:0]     lo_run_q;

  // Longest legal run of one level: the longer of the two periods
  localparam logic [CNT_W-1:0] RUN_LIM = (PERIOD_FAST_CYC > PERIOD_SLOW_CYC) ? PERIOD_FAST_CYC : PERIOD_SLOW_CYC;

  // Clamp a proportional high time into the legal duty window
  function automatic logic [CNT_W-1:0] duty_cycles(input logic [CNT_W-1:0] per,
                                                   input logic [POS_W-1:0] pos);
    logic [PROD_W-1:0] prod;
    logic [PROD_W-1:0] lo;
    logic [PROD_W-1:0] hi;
    prod = (PROD_W'(per) * PROD_W'(pos)) >> POS_W;
    // Floor rounded up, so a short period never gets a zero-length pulse
    lo   = (PROD_W'(per) * PROD_W'(DUTY_MIN_PCT) + PROD_W'(PCT_FULL - 1)) / PROD_W'(PCT_FULL);
    hi   = (PROD_W'(per) * PROD_W'(DUTY_MAX_PCT)) / PROD_W'(PCT_FULL);
    if (prod < lo) begin
      prod = lo;
    end else if (prod > hi) begin
      prod = hi;
    end
    return prod[CNT_W-1:0];
  endfunction

  // Pin synchronisers; reset to the pulled-up level
  // undriven select reads high
  pwmenc_sync #(.RESET_VAL(PIN_PULLUP)) u_sync_freq (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .PIN_IN  (FREQUENCY_SELECT),
    .LEVEL   (freq_lvl)
  );
  pwmenc_sync #(.RESET_VAL(PIN_PULLUP)) u_sync_doze (
    .CLK_SYS (CLK_SYS),
    .RST     (RST),
    .PIN_IN  (DOZE_CONTROL),
    .LEVEL   (doze_lvl)
  );

  // Last cycle of the current period
  assign bnd = (cnt_q == period_q - CNT_W'(1));

  always_comb begin
    period_d = freq_lvl ? PERIOD_FAST_CYC : PERIOD_SLOW_CYC;
    high_d   = duty_cycles(period_d, POSITION);
  end

  // sleep entered at period end, left at once
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (bnd && !doze_lvl) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (doze_lvl) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Period counter; held at zero while asleep
  // Clearing on the boundary keeps each period exactly period_q cycles long
  always_ff @(posedge CLK_SYS) begin
    if (RST || state_q == ST_SLEEP || bnd) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // load only at boundary or while asleep
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      period_q <= PERIOD_FAST_CYC;
      high_q   <= PERIOD_FAST_CYC >> 1;
    end else if (bnd || state_q == ST_SLEEP) begin
      period_q <= period_d;
      high_q   <= high_d;
    end
  end

  // Sleep forces the output low, so the host sees a steady low level
  // output high for high_q cycles of each period
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PULSE_WIDTH_OUT <= 1'h0;
      SLEEPING        <= 1'h0;
    end else begin
      PULSE_WIDTH_OUT <= (state_q == ST_RUN) && (cnt_q < high_q);
      SLEEPING        <= (state_q == ST_SLEEP);
    end
  end

  // Checks
  // period follows select
  a_rate_select: assert property (@(posedge CLK_SYS) disable iff (RST)
    bnd |=> period_q == ($past(freq_lvl) ? PERIOD_FAST_CYC : PERIOD_SLOW_CYC))
    else $error("period not loaded from select");
  a_select_pullup: assert property (@(posedge CLK_SYS)
    $fell(RST) |-> freq_lvl && period_q == PERIOD_FAST_CYC)
    else $error("select not high after reset");
  a_doze_sleep: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_q == ST_RUN && bnd && !doze_lvl) |=> state_q == ST_SLEEP ##1 !PULSE_WIDTH_OUT && SLEEPING)
    else $error("sleep not entered");
  a_doze_pullup: assert property (@(posedge CLK_SYS)
    $fell(RST) |-> state_q == ST_RUN && doze_lvl)
    else $error("not awake after reset");
  // Length of the current high run of the output, for the stuck-level check
  always_ff @(posedge CLK_SYS) begin
    if (RST || !PULSE_WIDTH_OUT) begin
      hi_run_q <= '0;
    end else begin
      hi_run_q <= hi_run_q + CNT_W'(1);
    end
  end

  // Length of the current low run while awake, for the stuck-level check
  always_ff @(posedge CLK_SYS) begin
    if (RST || PULSE_WIDTH_OUT || SLEEPING) begin
      lo_run_q <= '0;
    end else begin
      lo_run_q <= lo_run_q + CNT_W'(1);
    end
  end

  // high in the first cycle of a period
  a_duty_window: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_q == ST_RUN && cnt_q == '0) |=> PULSE_WIDTH_OUT)
    else $error("pulse missing at period start");
  // low after the last cycle of a period
  a_duty_end: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_q == ST_RUN && bnd) |=> !PULSE_WIDTH_OUT)
    else $error("pulse still high at period end");
  // while awake, no level runs longer than RUN_LIM, the longer of the two periods
  a_never_stuck: assert property (@(posedge CLK_SYS) disable iff (RST)
    hi_run_q <= RUN_LIM && lo_run_q <= RUN_LIM)
    else $error("output stuck at one level");
  a_wake_resume: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_q == ST_SLEEP && doze_lvl) |=> state_q == ST_RUN ##1 !SLEEPING)
    else $error("wake not taken");
  a_sleep_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
    SLEEPING |-> !PULSE_WIDTH_OUT)
    else $error("output active while asleep");
  // output tracks counter against high time
  a_pulse_track: assert property (@(posedge CLK_SYS) disable iff (RST)
    state_q == ST_RUN |=> PULSE_WIDTH_OUT == ($past(cnt_q) < $past(high_q)))
    else $error("pulse does not match high time");
  a_centre_half: assert property (@(posedge CLK_SYS) disable iff (RST)
    (bnd && POSITION == POS_CENTRE) |=> high_q == (period_q >> 1))
    else $error("centre not half duty");
  // no reload inside a running period
  a_hold_period: assert property (@(posedge CLK_SYS) disable iff (RST)
    (state_q == ST_RUN && !bnd) |=> $stable(period_q) && $stable(high_q))
    else $error("reload inside period");

  c_slow_rate: cover property (@(posedge CLK_SYS) disable iff (RST) bnd && !freq_lvl);
  c_sleep_wake: cover property (@(posedge CLK_SYS) disable iff (RST)
    state_q == ST_SLEEP ##1 state_q == ST_RUN);
  c_clamp_low: cover property (@(posedge CLK_SYS) disable iff (RST) bnd && POSITION == '0);
  // Main scenarios: top clamp and centre line
  c_clamp_high: cover property (@(posedge CLK_SYS) disable iff (RST) bnd && POSITION == '1);
  c_centre: cover property (@(posedge CLK_SYS) disable iff (RST)
    bnd && POSITION == POS_CENTRE);

endmodule
